// *** rtl/pwr_mode_pkg.sv ***
// Package for the halt, wake-up and operating mode controller
// Assumes a single 10 MHz clock and an APB register port
package pwr_mode_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [11:0] CLKCTL_OFF = 12'h000; // System clock control
	localparam logic [11:0] FOSC_OFF = 12'h004; // Fast oscillator control
	localparam logic [11:0] WAKE_OFF = 12'h008; // Port A wake enables
	localparam logic [11:0] STAT_OFF = 12'h00c; // Status flags and mode
	// ==========================================
	// Field positions in the clock control word
	localparam int SEL_LSB = 5; // Clock select, bits 7..5
	localparam int SRC_BIT = 2; // Slow source select
	localparam int FKEEP_BIT = 1; // Fast keep in halt
	localparam int SKEEP_BIT = 0; // Slow keep in halt
	// Field positions in the fast oscillator word
	localparam int FSTAB_BIT = 1; // Stable flag
	localparam int FEN_BIT = 0; // Enable
	// Field positions in the status word
	localparam int PD_BIT = 0; // Power-down flag
	localparam int TOUT_BIT = 1; // Time-out flag
	localparam int MODE_LSB = 4; // Operating mode, bits 6..4
	// ==========================================
	// Reset values
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic FEN_RST = 1'b1;
	localparam logic [2:0] SEL_SLOW = 3'h7; // Code that picks the slow clock
	// ==========================================
	// Timing: fast oscillator start-up
	localparam int CLK_HZ = 10_000_000;
	localparam int FOSC_START_US = 16; // Start-up time in microseconds
	localparam int FOSC_START_CYC = (FOSC_START_US * (CLK_HZ / 1_000_000));
	// ==========================================
	// Operating modes
	typedef enum logic [2:0] {
		M_FAST = 3'b000,
		M_SLOW = 3'b001,
		M_SLEEP = 3'b010,
		M_IDLE0 = 3'b011,
		M_IDLE1 = 3'b100,
		M_IDLE2 = 3'b101,
		M_WAKE = 3'b110
	} pmode_t;
endpackage

// *** rtl/power_mode_halt_wakeup_control.sv ***
// Halt, wake-up and clock mode controller with an APB register port
// Assumes halt, clear-watchdog and interrupt strobes from the core on clk
// What this block does
// - Codes 000-110 select fast clock divided
// - Halt with both keeps low: sleep
// - Fast keep 0, slow keep 1: idle0
// - Both keeps high: idle1, clocks run
// - Fast keep 1, slow keep 0: idle2
// - Halt stops core, state preserved
// - Halt sets power-down, clears time-out
// - Halt clears watchdog, runs if enabled
// - Wake to fast waits stable flag
// - Only port edge, interrupt, watchdog wake
// - Power-down cleared by reset, clear-watchdog
// - Watchdog wake sets time-out, resets PC/SP
// - Per-pin wake enable, resume after halt
// - Disabled interrupt wake resumes, stays pending
// - Enabled interrupt with free stack vectors
// - Interrupts pending at halt cannot wake
// - Peripherals follow the system clock source
// - Start on fast stable, not slow crystal
// - Source select: 0 RC, 1 crystal
// - Code 111 selects slow clock when stable
// - Fast enable clears then sets stable
//
// The implementer's own choices: the register offsets and the APB slave port.
module power_mode_halt_wakeup_control
	import pwr_mode_pkg::*;
#(
	parameter int PA_W = 8, // Port A width
	parameter int IRQ_W = 8, // Interrupt source count
	parameter int START_CYC = FOSC_START_CYC // Fast oscillator start-up cycles
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic halt_exec,
	input wire logic clr_wdt_exec,
	input wire logic wdt_enable,
	input wire logic wdt_overflow,
	input wire logic [IRQ_W-1:0] irq_req,
	input wire logic [IRQ_W-1:0] irq_en,
	input wire logic stack_full,
	input wire logic slow_osc_stable,
	input wire logic [PA_W-1:0] port_a_pin,
	output logic cpu_run,
	output logic core_hold,
	output logic wdt_clear,
	output logic wdt_run,
	output logic pc_sp_reset,
	output logic irq_take,
	output logic fast_osc_on,
	output logic slow_osc_on,
	output logic slow_src_crystal,
	output logic sys_clk_slow,
	output logic [2:0] fast_div_sel,
	output logic periph_clk_slow
);
	// ==========================================
	// Registers
	logic [2:0] sysclk_select_q; // Clock select field
	logic slow_clock_source_select_q; // Slow source
	logic fast_osc_keep_in_halt_q; // Fast keep bit
	logic slow_osc_keep_in_halt_q; // Slow keep bit
	logic fast_osc_enable_q; // Fast oscillator enable
	logic fast_osc_stable_flag_q; // Fast stable flag
	logic [PA_W-1:0] port_a_wake_enable_q; // Wake enables
	logic power_down_flag_q; // Power-down flag
	logic watchdog_timeout_flag_q; // Time-out flag
	pmode_t mode_q; // Present operating mode
	logic [IRQ_W-1:0] irq_armed_q; // Interrupts allowed to wake
	logic [31:0] start_cnt_q; // Start-up counter
	logic slow_active_q; // Slow clock actually in use
	logic [PA_W-1:0] pa_s1_q; // Pin sync stage 1
	logic [PA_W-1:0] pa_s2_q; // Pin sync stage 2
	logic [PA_W-1:0] pa_s3_q; // Previous synced level
	logic pc_sp_reset_q; // Watchdog wake pulse
	logic irq_take_q; // Interrupt response pulse
	logic [31:0] prdata_q; // Read data
	logic wr_en; // APB write strobe
	logic halted; // In sleep or idle
	logic pin_wake; // Enabled falling edge
	logic irq_wake; // Armed interrupt
	logic irq_serviceable; // Waking interrupt can vector
	logic wake_ev; // Any wake-up source
	logic fast_en_rise; // Enable write 0 to 1

	// Single-cycle APB slave, no wait states
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel && penable && pwrite;
	assign halted = (mode_q == M_SLEEP) || (mode_q == M_IDLE0) || (mode_q == M_IDLE1) || (mode_q == M_IDLE2);

	// ==========================================
	// Clock control and wake enable register writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sysclk_select_q <= SEL_RST;
			slow_clock_source_select_q <= 1'b0;
			fast_osc_keep_in_halt_q <= 1'b0;
			slow_osc_keep_in_halt_q <= 1'b0;
			port_a_wake_enable_q <= '0;
		end else if (wr_en) begin
			if (paddr == CLKCTL_OFF) begin
				sysclk_select_q <= pwdata[SEL_LSB+:3];
				slow_clock_source_select_q <= pwdata[SRC_BIT];
				fast_osc_keep_in_halt_q <= pwdata[FKEEP_BIT];
				slow_osc_keep_in_halt_q <= pwdata[SKEEP_BIT];
			end
			if (paddr == WAKE_OFF) begin
				port_a_wake_enable_q <= pwdata[PA_W-1:0];
			end
		end
	end

	// ==========================================
	// Fast oscillator enable
	assign fast_en_rise = wr_en && (paddr == FOSC_OFF) && pwdata[FEN_BIT] && !fast_osc_enable_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fast_osc_enable_q <= FEN_RST;
		end else if (wr_en && (paddr == FOSC_OFF)) begin
			fast_osc_enable_q <= pwdata[FEN_BIT];
		end
	end

	// Oscillator runs if enabled and not stopped by halt mode
	assign fast_osc_on = fast_osc_enable_q && !(mode_q == M_SLEEP || mode_q == M_IDLE0);
	assign slow_osc_on = !(mode_q == M_SLEEP || mode_q == M_IDLE2);

	// ==========================================
	// Stable flag: cleared on start, set after start-up count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			start_cnt_q <= '0;
			fast_osc_stable_flag_q <= 1'b0;
		end else if (!fast_osc_on || fast_en_rise) begin
			start_cnt_q <= '0;
			fast_osc_stable_flag_q <= 1'b0;
		end else if (start_cnt_q < START_CYC - 1) begin
			start_cnt_q <= start_cnt_q + 32'h0000_0001;
		end else begin
			fast_osc_stable_flag_q <= 1'b1;
		end
	end

	// ==========================================
	// Port A pin synchroniser and falling edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pa_s1_q <= '1;
			pa_s2_q <= '1;
			pa_s3_q <= '1;
		end else begin
			pa_s1_q <= port_a_pin;
			pa_s2_q <= pa_s1_q;
			pa_s3_q <= pa_s2_q;
		end
	end
	assign pin_wake = |(port_a_wake_enable_q & pa_s3_q & ~pa_s2_q);

	// ==========================================
	// Interrupts pending at halt lose wake-up ability
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_armed_q <= '0;
		end else if (halt_exec && !halted) begin
			irq_armed_q <= ~irq_req;
		end
	end
	assign irq_wake = |(irq_req & irq_armed_q);
	assign irq_serviceable = |(irq_req & irq_armed_q & irq_en) && !stack_full;
	assign wake_ev = pin_wake || irq_wake || wdt_overflow;

	// ==========================================
	// Operating mode state machine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= M_WAKE;
		end else begin
			unique case (mode_q)
				M_FAST, M_SLOW: begin
					if (halt_exec) begin
						// Keep bits taken at the halt itself
						unique case ({fast_osc_keep_in_halt_q, slow_osc_keep_in_halt_q})
							2'b00: mode_q <= M_SLEEP;
							2'b01: mode_q <= M_IDLE0;
							2'b11: mode_q <= M_IDLE1;
							2'b10: mode_q <= M_IDLE2;
						endcase
					end else if (slow_active_q) begin
						mode_q <= M_SLOW;
					end else begin
						mode_q <= M_FAST;
					end
				end
				M_SLEEP, M_IDLE0, M_IDLE1, M_IDLE2: begin
					if (wake_ev) begin
						mode_q <= M_WAKE;
					end
				end
				M_WAKE: begin
					// Resume once selected clock is usable
					if (sysclk_select_q == SEL_SLOW) begin
						if (slow_osc_stable) begin
							mode_q <= M_SLOW;
						end
					end else if (fast_osc_stable_flag_q) begin
						mode_q <= M_FAST;
					end
				end
				default: mode_q <= M_WAKE;
			endcase
		end
	end
	assign cpu_run = (mode_q == M_FAST) || (mode_q == M_SLOW);
	assign core_hold = !cpu_run;

	// ==========================================
	// Clock source: goes slow once slow oscillator stable, stays slow until select code changes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slow_active_q <= 1'b0;
		end else if (sysclk_select_q != SEL_SLOW) begin
			slow_active_q <= 1'b0;
		end else if (slow_osc_stable) begin
			slow_active_q <= 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sys_clk_slow <= 1'b0;
			fast_div_sel <= SEL_RST;
			slow_src_crystal <= 1'b0;
			periph_clk_slow <= 1'b0;
		end else begin
			sys_clk_slow <= slow_active_q;
			fast_div_sel <= (sysclk_select_q == SEL_SLOW) ? fast_div_sel : sysclk_select_q;
			slow_src_crystal <= slow_clock_source_select_q;
			periph_clk_slow <= slow_active_q;
		end
	end

	// ==========================================
	// Status flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_down_flag_q <= 1'b0;
			watchdog_timeout_flag_q <= 1'b0;
		end else if (halt_exec && cpu_run) begin
			power_down_flag_q <= 1'b1;
			watchdog_timeout_flag_q <= 1'b0;
		end else begin
			if (clr_wdt_exec && cpu_run) begin
				power_down_flag_q <= 1'b0;
			end
			if (halted && wdt_overflow) begin
				watchdog_timeout_flag_q <= 1'b1;
			end
		end
	end
	assign wdt_clear = halt_exec && cpu_run;
	assign wdt_run = wdt_enable;

	// ==========================================
	// Wake-up response pulses
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc_sp_reset_q <= 1'b0;
			irq_take_q <= 1'b0;
		end else begin
			pc_sp_reset_q <= halted && wdt_overflow;
			irq_take_q <= halted && !wdt_overflow && irq_serviceable;
		end
	end
	assign pc_sp_reset = pc_sp_reset_q;
	assign irq_take = irq_take_q;

	// ==========================================
	// APB read data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= 32'h0000_0000;
			unique case (paddr)
				CLKCTL_OFF: prdata_q <= {24'h00_0000, sysclk_select_q, 2'b00, slow_clock_source_select_q,
					fast_osc_keep_in_halt_q, slow_osc_keep_in_halt_q};
				FOSC_OFF: prdata_q <= {30'h0000_0000, fast_osc_stable_flag_q, fast_osc_enable_q};
				WAKE_OFF: prdata_q[PA_W-1:0] <= port_a_wake_enable_q;
				STAT_OFF: prdata_q <= {25'h000_0000, mode_q, 2'b00, watchdog_timeout_flag_q, power_down_flag_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign prdata = prdata_q;

	// ==========================================
	// Checks
	property p_halt_sets_pd;
		@(posedge clk) disable iff (!rst_n) (halt_exec && cpu_run) |=> (power_down_flag_q && !watchdog_timeout_flag_q);
	endproperty
	a_halt_sets_pd: assert property (p_halt_sets_pd) else $error("halt did not set pd");
	property p_sleep_entry;
		@(posedge clk) disable iff (!rst_n)
			(halt_exec && cpu_run && !fast_osc_keep_in_halt_q && !slow_osc_keep_in_halt_q) |=> (mode_q == M_SLEEP);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep entry");
	property p_idle0;
		@(posedge clk) disable iff (!rst_n) (mode_q == M_IDLE0) |-> (!fast_osc_on && slow_osc_on);
	endproperty
	a_idle0: assert property (p_idle0) else $error("idle0 clocks wrong");
	property p_idle1;
		@(posedge clk) disable iff (!rst_n)
			(halt_exec && cpu_run && fast_osc_keep_in_halt_q && slow_osc_keep_in_halt_q) |=> (mode_q == M_IDLE1);
	endproperty
	a_idle1: assert property (p_idle1) else $error("no idle1 entry");
	property p_idle2;
		@(posedge clk) disable iff (!rst_n) (mode_q == M_IDLE2) |-> !slow_osc_on;
	endproperty
	a_idle2: assert property (p_idle2) else $error("idle2 slow clock on");
	property p_hold;
		@(posedge clk) disable iff (!rst_n) (halted && !wake_ev) |=> (core_hold && $stable(mode_q));
	endproperty
	a_hold: assert property (p_hold) else $error("core runs while halted");
	property p_wake_fast;
		@(posedge clk) disable iff (!rst_n)
			($past(mode_q) == M_WAKE && mode_q == M_FAST) |-> $past(fast_osc_stable_flag_q);
	endproperty
	a_wake_fast: assert property (p_wake_fast) else $error("ran before stable");
	property p_wdt_wake;
		@(posedge clk) disable iff (!rst_n)
			(halted && wdt_overflow) |=> (pc_sp_reset && watchdog_timeout_flag_q && mode_q == M_WAKE);
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake wrong");
	property p_pd_clear;
		@(posedge clk) disable iff (!rst_n) ($fell(power_down_flag_q)) |-> $past(clr_wdt_exec);
	endproperty
	a_pd_clear: assert property (p_pd_clear) else $error("pd cleared wrongly");
	property p_stable_clear;
		@(posedge clk) disable iff (!rst_n) fast_en_rise |=> !fast_osc_stable_flag_q;
	endproperty
	a_stable_clear: assert property (p_stable_clear) else $error("stable not cleared");
	property p_wake_src;
		@(posedge clk) disable iff (!rst_n) (halted && wake_ev) |=> (mode_q == M_WAKE);
	endproperty
	a_wake_src: assert property (p_wake_src) else $error("wake source ignored");
	property p_pin_wake;
		@(posedge clk) disable iff (!rst_n)
			(halted && pin_wake && !wdt_overflow) |=> (mode_q == M_WAKE && !pc_sp_reset);
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("pin edge wake wrong");
	property p_irq_take;
		@(posedge clk) disable iff (!rst_n)
			(halted && !wdt_overflow && irq_serviceable) |=> (irq_take && mode_q == M_WAKE);
	endproperty
	a_irq_take: assert property (p_irq_take) else $error("no interrupt response");
	property p_irq_masked;
		@(posedge clk) disable iff (!rst_n)
			(halted && !pin_wake && !wdt_overflow && !(|(irq_req & irq_armed_q))) |=> (halted && !irq_take);
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("disarmed interrupt woke");
	property p_slow_switch;
		@(posedge clk) disable iff (!rst_n)
			$rose(slow_active_q) |-> ($past(slow_osc_stable) && ($past(sysclk_select_q) == SEL_SLOW));
	endproperty
	a_slow_switch: assert property (p_slow_switch) else $error("slow clock before stable");
	property p_slow_resume;
		@(posedge clk) disable iff (!rst_n)
			(mode_q == M_WAKE && sysclk_select_q == SEL_SLOW) |=> (mode_q != M_FAST);
	endproperty
	a_slow_resume: assert property (p_slow_resume) else $error("woke into wrong clock");
endmodule

// *** verif/core_side_model.sv ***
// Partner model: processor core halt gating and slow oscillator settling
// Assumes the bench asks for halts on halt_req, all on the one clock
module core_side_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_run,
	input wire logic slow_osc_on,
	input wire logic halt_req,
	output logic halt_exec,
	output logic slow_osc_stable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] settle_q; // Slow oscillator settle count
	// ==========================================
	// Core only issues a halt while it executes
	assign halt_exec = halt_req && cpu_run;
	// Slow clock settles three cycles after it is switched on, drops on the next clock edge when off
	always_ff @(posedge clk) begin
		if (!rst_n || !slow_osc_on) begin
			settle_q <= 2'h0;
		end else if (settle_q != 2'h3) begin
			settle_q <= settle_q + 2'h1;
		end
	end
	assign slow_osc_stable = (settle_q == 2'h3);
endmodule

// *** verif/power_mode_halt_wakeup_control_tb.sv ***
// Self-checking bench for the halt, wake-up and clock mode controller
// Assumes 10 MHz clk, APB slave that answers at once, core partner model
module power_mode_halt_wakeup_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pwr_mode_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, halt_req = 0, clr_wdt_exec = 0;
	logic wdt_enable = 0, wdt_overflow = 0, stack_full = 0, halt_exec, slow_osc_stable;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, lfsr = 32'h0000_7700, q;
	logic [7:0] irq_req = '0, irq_en = '0, port_a_pin = '1;
	logic pready, pslverr, cpu_run, core_hold, wdt_clear, wdt_run, pc_sp_reset, irq_take;
	logic fast_osc_on, slow_osc_on, slow_src_crystal, sys_clk_slow, periph_clk_slow;
	logic [2:0] fast_div_sel;
	logic [31:0] exp_q[$], msk_q[$]; // Expected read data and masks
	int errors = 0, n_compared = 0, n_irq = 0, n_pcsp = 0, b_irq, b_pcsp, k, n;
	pmode_t halt_mode[4] = '{M_SLEEP, M_IDLE0, M_IDLE2, M_IDLE1}; // Indexed by {fast keep, slow keep}
	// ==========================================
	// Design, partner and clock
	power_mode_halt_wakeup_control #(.PA_W(8), .IRQ_W(8), .START_CYC(4)) i_power_mode_halt_wakeup_control (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
		.clr_wdt_exec(clr_wdt_exec), .wdt_enable(wdt_enable), .wdt_overflow(wdt_overflow), .irq_req(irq_req),
		.irq_en(irq_en), .stack_full(stack_full), .slow_osc_stable(slow_osc_stable), .port_a_pin(port_a_pin),
		.cpu_run(cpu_run), .core_hold(core_hold), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
		.pc_sp_reset(pc_sp_reset), .irq_take(irq_take), .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on),
		.slow_src_crystal(slow_src_crystal), .sys_clk_slow(sys_clk_slow), .fast_div_sel(fast_div_sel),
		.periph_clk_slow(periph_clk_slow));
	core_side_model i_core_side_model (.clk(clk), .rst_n(rst_n), .cpu_run(cpu_run), .slow_osc_on(slow_osc_on),
		.halt_req(halt_req), .halt_exec(halt_exec), .slow_osc_stable(slow_osc_stable));
	always #50 clk = ~clk;
	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic report_and_stop;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int m;
		m = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			m++;
		end while (pready !== 1'b1 && m < 50);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (m >= 50) begin
			errors++;
			report_and_stop();
		end
	endtask
	// Read with the expectation noted for the monitor
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// Bounded wait for the core to run or stop
	task automatic wait_run(input logic v);
		n = 0;
		while (cpu_run !== v && n < 60) begin
			@(posedge clk);
			n++;
		end
		if (cpu_run !== v) begin
			errors++;
			report_and_stop();
		end
	endtask
	task automatic do_halt;
		@(posedge clk);
		halt_req <= 1'b1;
		@(negedge clk);
		chk(wdt_clear, 1'b1);
		chk(wdt_run, wdt_enable);
		@(posedge clk);
		halt_req <= 1'b0;
		@(negedge clk);
		chk(core_hold, 1'b1);
	endtask
	// ==========================================
	// Monitor: read data against the oldest note, pulse counts
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			chk(prdata & msk_q.pop_front(), exp_q.pop_front());
		end
		if (psel && penable && pready) begin
			chk(pslverr, 1'b0);
		end
		if (irq_take === 1'b1) n_irq++;
		if (pc_sp_reset === 1'b1) n_pcsp++;
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wait_run(1'b1);
		rd(FOSC_OFF, 32'h0000_0003, 32'h0000_0003);
		rd(CLKCTL_OFF, 32'h0000_0000, 32'h0000_00ff);
		rd(STAT_OFF, 32'h0000_0000, 32'h0000_0073);
		apb(1'b1, 12'h010, 32'hffff_ffff);
		rd(12'h010, 32'h0000_0000, 32'hffff_ffff);
		apb(1'b1, WAKE_OFF, 32'h0000_0001);
		// Every keep combination, woken by pin edge, interrupt, interrupt with stack full, watchdog
		for (k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			wdt_enable <= lfsr[0];
			apb(1'b1, CLKCTL_OFF, 32'(k));
			b_irq = n_irq;
			b_pcsp = n_pcsp;
			do_halt();
			chk(fast_osc_on, 32'(k[1]));
			chk(slow_osc_on, 32'(k[0]));
			rd(STAT_OFF, {halt_mode[k], 4'h1}, 32'h0000_0073);
			if (k == 0) port_a_pin[0] <= 1'b0;
			if (k == 1) begin
				port_a_pin[1] <= 1'b0;
				repeat (8) @(posedge clk);
				chk(core_hold, 1'b1);
				irq_en[lfsr[3:1]] <= 1'b1;
				irq_req[lfsr[3:1]] <= 1'b1;
			end
			if (k == 2) begin
				stack_full <= 1'b1;
				irq_en[lfsr[3:1]] <= lfsr[4];
				irq_req[lfsr[3:1]] <= 1'b1;
			end
			if (k == 3) begin
				wdt_overflow <= 1'b1;
				@(posedge clk);
				wdt_overflow <= 1'b0;
			end
			wait_run(1'b1);
			rd(STAT_OFF, {M_FAST, 2'b00, k == 3, 1'b1}, 32'h0000_0073);
			if (k == 0) rd(FOSC_OFF, 32'h0000_0003, 32'h0000_0003);
			chk(n_irq - b_irq, 32'(k == 1));
			chk(n_pcsp - b_pcsp, 32'(k == 3));
			port_a_pin <= '1;
			irq_req <= '0;
			irq_en <= '0;
			stack_full <= 1'b0;
		end
		@(posedge clk);
		clr_wdt_exec <= 1'b1;
		@(posedge clk);
		clr_wdt_exec <= 1'b0;
		rd(STAT_OFF, 32'h0000_0002, 32'h0000_0073);
		// Request already set at halt cannot wake
		irq_req[5] <= 1'b1;
		apb(1'b1, CLKCTL_OFF, 32'h0000_0003);
		do_halt();
		repeat (8) @(posedge clk);
		chk(core_hold, 1'b1);
		port_a_pin[0] <= 1'b0;
		wait_run(1'b1);
		port_a_pin <= '1;
		irq_req <= '0;
		// Slow mode from the crystal, then halt and wake back into it
		apb(1'b1, CLKCTL_OFF, 32'h0000_00e4);
		for (n = 0; n < 50 && sys_clk_slow !== 1'b1; n++) @(posedge clk);
		@(negedge clk);
		chk(sys_clk_slow, 1'b1);
		chk(periph_clk_slow, 1'b1);
		chk(slow_src_crystal, 1'b1);
		do_halt();
		port_a_pin[0] <= 1'b0;
		wait_run(1'b1);
		rd(STAT_OFF, {M_SLOW, 4'h1}, 32'h0000_0073);
		port_a_pin <= '1;
		apb(1'b1, CLKCTL_OFF, 32'h0000_00e0);
		@(posedge clk);
		@(negedge clk);
		chk(slow_src_crystal, 1'b0);
		// Fast oscillator restart while running slow
		apb(1'b1, FOSC_OFF, 32'h0000_0000);
		@(negedge clk);
		chk(fast_osc_on, 1'b0);
		apb(1'b1, FOSC_OFF, 32'h0000_0001);
		rd(FOSC_OFF, 32'h0000_0001, 32'h0000_0003);
		for (n = 0; n < 20 && q[FSTAB_BIT] !== 1'b1; n++) rd(FOSC_OFF, 32'h0000_0001, 32'h0000_0001);
		chk(q[FSTAB_BIT], 1'b1);
		// Every fast divide code
		for (k = 0; k < 7; k++) begin
			apb(1'b1, CLKCTL_OFF, {24'h0, k[2:0], 5'h00});
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk(sys_clk_slow, 1'b0);
			chk(fast_div_sel, k[2:0]);
		end
		report_and_stop();
	end
endmodule
